/* File: cca_cfg.svh */
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH

// =====================================================================
// register addresses on the special-function bus
`define CCA_ADDR_CH2_MODE 8'hdc
`define CCA_ADDR_CH1_LOW  8'he9
`define CCA_ADDR_CH1_HIGH 8'hea
`define CCA_ADDR_CH2_LOW  8'heb
`define CCA_ADDR_CH2_HIGH 8'hec

// =====================================================================
// reset values, masks and the base pwm width
`define CCA_RST_BYTE   8'h00
`define CCA_RST_WORD   16'h0000
`define CCA_FULL_MASK  16'hffff
`define CCA_LOW_MASK   16'h00ff
`define CCA_BASE_WIDTH 5'h08

`endif

/* File: cca_pkg.sv */
package cca_pkg;

    // =================================================================
    // channel mode byte, bit 7 down to bit 0
    typedef struct packed {
        logic wideWidthSelect;       // 16-bit pwm when set
        logic comparatorEnable;      // compare logic active
        logic risingCaptureEnable;   // capture on rising input edge
        logic fallingCaptureEnable;  // capture on falling input edge
        logic matchFlagEnable;       // match sets the channel flag
        logic toggleEnable;          // match inverts the output pin
        logic pwmEnable;             // pulse width modulation
        logic flagInterruptEnable;   // flag raises an interrupt request
    } cca_mode_t;

    // =================================================================
    // one special-function bus request
    typedef struct packed {
        logic [7:0] addr;            // register address
        logic       wrEn;            // write strobe
        logic       rdEn;            // read strobe
        logic [7:0] wrData;          // write data
    } cca_sfr_req_t;

endpackage

/* File: cca_chan_engine.sv */
`timescale 1ns/1ps
`include "cca_cfg.svh"

module cca_chan_engine
    import cca_pkg::*;
(
    input  wire logic        clk,             // system clock
    input  wire logic        rst_n,           // async reset, active low
    input  wire cca_mode_t   mode,            // channel mode byte
    input  wire logic [15:0] counter,         // shared counter value
    input  wire logic        counterTick,     // counter holds a fresh value
    input  wire logic [15:0] ccValue,         // capture/compare value
    input  wire logic [1:0]  widthSel,        // 8 + n bit pwm width
    input  wire logic        capPin,          // capture input pin
    output logic             matchPulse,      // compare hit, one cycle
    output logic             flagSet,         // flag set request, one cycle
    output logic             captureStrobe,   // capture taken, one cycle
    output logic [15:0]      captureValue,    // counter value at capture
    output logic             reloadPulse,     // narrow pwm wrapped
    output logic             freqStep,        // frequency output step
    output logic             pinOut           // channel output pin
);

    // =================================================================
    // state
    logic        capMeta_reg, capSync_reg, capPrev_reg;
    logic        pin_reg, pin_next;
    logic        match_reg, match_next;
    logic        flag_reg, flag_next;
    logic        cap_reg, cap_next;
    logic [15:0] capVal_reg, capVal_next;
    logic        reload_reg, reload_next;
    logic        step_reg, step_next;
    logic [15:0] widthMask, pwmMask, matchMask;
    logic        hit, rise, fall, capHit;
    logic [4:0]  shamt;

    // compare, capture and pin next values
    always_comb
    begin
        shamt     = `CCA_BASE_WIDTH + {3'h0, widthSel};
        widthMask = ~(`CCA_FULL_MASK << shamt);
        pwmMask   = mode.wideWidthSelect ? `CCA_FULL_MASK : widthMask;
        // frequency output compares the low byte only
        matchMask = (mode.pwmEnable && mode.toggleEnable) ? `CCA_LOW_MASK :
                    (mode.pwmEnable ? pwmMask : `CCA_FULL_MASK);
        hit       = counterTick && mode.comparatorEnable &&
                    (((counter ^ ccValue) & matchMask) == `CCA_RST_WORD);
        rise      = capSync_reg & ~capPrev_reg;
        fall      = ~capSync_reg & capPrev_reg;
        capHit    = (rise & mode.risingCaptureEnable) |
                    (fall & mode.fallingCaptureEnable);
        pin_next  = pin_reg;
        if (mode.comparatorEnable)
        begin
            if (mode.toggleEnable)
            begin
                if (hit)
                    pin_next = ~pin_reg;
            end
            else if (mode.pwmEnable && counterTick)
                pin_next = (counter & pwmMask) >= (ccValue & pwmMask);
        end
        match_next  = hit;
        flag_next   = (hit & mode.matchFlagEnable) | capHit;
        cap_next    = capHit;
        capVal_next = capHit ? counter : capVal_reg;
        // narrow pwm picks up its reload value when the counter wraps
        reload_next = counterTick && mode.comparatorEnable && mode.pwmEnable &&
                      !mode.toggleEnable && !mode.wideWidthSelect &&
                      ((counter & widthMask) == `CCA_RST_WORD);
        step_next   = hit && mode.pwmEnable && mode.toggleEnable;
    end

    // registers; the first sync flop feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capMeta_reg <= 1'b0;
            capSync_reg <= 1'b0;
            capPrev_reg <= 1'b0;
            pin_reg     <= 1'b0;
            match_reg   <= 1'b0;
            flag_reg    <= 1'b0;
            cap_reg     <= 1'b0;
            capVal_reg  <= `CCA_RST_WORD;
            reload_reg  <= 1'b0;
            step_reg    <= 1'b0;
        end
        else
        begin
            capMeta_reg <= capPin;
            capSync_reg <= capMeta_reg;
            capPrev_reg <= capSync_reg;
            pin_reg     <= pin_next;
            match_reg   <= match_next;
            flag_reg    <= flag_next;
            cap_reg     <= cap_next;
            capVal_reg  <= capVal_next;
            reload_reg  <= reload_next;
            step_reg    <= step_next;
        end
    end

    assign matchPulse    = match_reg;
    assign flagSet       = flag_reg;
    assign captureStrobe = cap_reg;
    assign captureValue  = capVal_reg;
    assign reloadPulse   = reload_reg;
    assign freqStep      = step_reg;
    assign pinOut        = pin_reg;

    // =================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence riseSeen;
        capSync_reg && !capPrev_reg && mode.risingCaptureEnable;
    endsequence
    sequence fallSeen;
        !capSync_reg && capPrev_reg && mode.fallingCaptureEnable;
    endsequence

    rise_capture_a: assert property (riseSeen |=> captureStrobe && flagSet && captureValue == $past(counter))
        else $error("rising edge capture missed");
    fall_capture_a: assert property (fallSeen |=> captureStrobe && flagSet)
        else $error("falling edge capture missed");
    no_compare_a: assert property (!mode.comparatorEnable |=> !matchPulse)
        else $error("compare hit while comparator disabled");
    match_flag_a: assert property (matchPulse && $past(mode.matchFlagEnable) |-> flagSet)
        else $error("match did not set channel flag");
    toggle_pin_a: assert property (hit && mode.toggleEnable |=> pinOut != $past(pinOut))
        else $error("toggle on match missing");
    pwm_level_a: assert property (mode.comparatorEnable && mode.pwmEnable && !mode.toggleEnable && counterTick
        |=> pinOut == (($past(counter) & $past(pwmMask)) >= ($past(ccValue) & $past(pwmMask))))
        else $error("pwm level wrong");
endmodule

/* File: cca_channel_regs.sv */
`timescale 1ns/1ps
`include "cca_cfg.svh"

module cca_channel_regs
    import cca_pkg::*;
(
    input  wire logic         clk,               // system clock, 250 MHz
    input  wire logic         rst_n,             // async reset, active low
    input  wire cca_sfr_req_t sfrReq,            // register bus request
    output logic [7:0]        sfrRdData,         // read data, one cycle after rdEn
    output logic              sfrRdValid,        // read answered, one cycle
    input  wire logic         reloadAliasSelect, // bytes reach the reload value
    input  wire logic [1:0]   widthSel,          // narrow pwm width, 8 + n
    input  wire logic [15:0]  counter,           // shared counter
    input  wire logic         counterTick,       // counter freshly advanced
    input  wire cca_mode_t    ch1ModeIn,         // channel 1 mode byte
    input  wire logic         ch1CapPin,         // channel 1 capture pin
    input  wire logic         ch1Flag,           // channel 1 flag level
    output logic              ch1CompEnSet,      // set channel 1 comparator enable
    output logic              ch1CompEnClr,      // clear channel 1 comparator enable
    output logic              ch1FlagSet,        // set channel 1 flag
    output logic              ch1IrqReq,         // channel 1 interrupt request
    output logic              ch1OutPin,         // channel 1 output pin
    input  wire logic [15:0]  ch2CompareIn,      // channel 2 compare value
    input  wire logic         ch2CapPin,         // channel 2 capture pin
    input  wire logic         ch2Flag,           // channel2_event_flag level
    output logic              ch2FlagSet,        // set channel2_event_flag
    output logic              ch2IrqReq,         // channel 2 interrupt request
    output logic              ch2CaptureStrobe,  // channel 2 capture taken
    output logic [15:0]       ch2CaptureValue,   // channel 2 captured counter
    output logic              ch2OutputPin,      // channel2_output_pin
    output cca_mode_t         ch2ModeOut         // channel2_mode_config contents
);

    // =================================================================
    // registers
    logic [15:0] ch1Cc_reg, ch1Cc_next;
    logic [15:0] ch1Reload_reg, ch1Reload_next;
    cca_mode_t   ch2Mode_reg, ch2Mode_next;
    logic [7:0]  rdData_reg, rdData_next;
    logic        rdValid_reg;
    logic        compEnSet_reg, compEnSet_next;
    logic        compEnClr_reg, compEnClr_next;
    logic        wrCh1Low, wrCh1High;
    logic        ch1Cap, ch1Reload, ch1Step;
    logic [15:0] ch1CapVal;

    assign wrCh1Low  = sfrReq.wrEn && (sfrReq.addr == `CCA_ADDR_CH1_LOW);
    assign wrCh1High = sfrReq.wrEn && (sfrReq.addr == `CCA_ADDR_CH1_HIGH);

    // =================================================================
    // channel engines
    cca_chan_engine u_ch1
    (
        .clk           (clk),
        .rst_n         (rst_n),
        .mode          (ch1ModeIn),
        .counter       (counter),
        .counterTick   (counterTick),
        .ccValue       (ch1Cc_reg),
        .widthSel      (widthSel),
        .capPin        (ch1CapPin),
        .matchPulse    (),
        .flagSet       (ch1FlagSet),
        .captureStrobe (ch1Cap),
        .captureValue  (ch1CapVal),
        .reloadPulse   (ch1Reload),
        .freqStep      (ch1Step),
        .pinOut        (ch1OutPin)
    );

    cca_chan_engine u_ch2
    (
        .clk           (clk),
        .rst_n         (rst_n),
        .mode          (ch2Mode_reg),
        .counter       (counter),
        .counterTick   (counterTick),
        .ccValue       (ch2CompareIn),
        .widthSel      (widthSel),
        .capPin        (ch2CapPin),
        .matchPulse    (),
        .flagSet       (ch2FlagSet),
        .captureStrobe (ch2CaptureStrobe),
        .captureValue  (ch2CaptureValue),
        .reloadPulse   (),
        .freqStep      (),
        .pinOut        (ch2OutputPin)
    );

    // =================================================================
    // register next values; a software byte write wins over hardware
    // updates of the same byte so a program never loses its own write
    always_comb
    begin
        ch1Cc_next     = ch1Cc_reg;
        ch1Reload_next = ch1Reload_reg;
        ch2Mode_next   = ch2Mode_reg;
        if (ch1Step)
            ch1Cc_next[7:0] = ch1Cc_reg[7:0] + ch1Cc_reg[15:8];
        if (ch1Reload)
            ch1Cc_next = ch1Reload_reg;
        if (ch1Cap)
            ch1Cc_next = ch1CapVal;
        if (wrCh1Low)
        begin
            if (reloadAliasSelect)
                ch1Reload_next[7:0] = sfrReq.wrData;
            else
                ch1Cc_next[7:0] = sfrReq.wrData;
        end
        if (wrCh1High)
        begin
            if (reloadAliasSelect)
                ch1Reload_next[15:8] = sfrReq.wrData;
            else
                ch1Cc_next[15:8] = sfrReq.wrData;
        end
        if (sfrReq.wrEn && sfrReq.addr == `CCA_ADDR_CH2_MODE)
            ch2Mode_next = cca_mode_t'(sfrReq.wrData);
        // channel 2 byte writes land outside but still steer its enable
        if (sfrReq.wrEn && sfrReq.addr == `CCA_ADDR_CH2_LOW)
            ch2Mode_next.comparatorEnable = 1'b0;
        if (sfrReq.wrEn && sfrReq.addr == `CCA_ADDR_CH2_HIGH)
            ch2Mode_next.comparatorEnable = 1'b1;
        compEnClr_next = wrCh1Low;
        compEnSet_next = wrCh1High;
        // read mux; unmapped addresses read as zero
        case (sfrReq.addr)
            `CCA_ADDR_CH1_LOW:  rdData_next = reloadAliasSelect ? ch1Reload_reg[7:0]  : ch1Cc_reg[7:0];
            `CCA_ADDR_CH1_HIGH: rdData_next = reloadAliasSelect ? ch1Reload_reg[15:8] : ch1Cc_reg[15:8];
            `CCA_ADDR_CH2_MODE: rdData_next = ch2Mode_reg;
            default:            rdData_next = `CCA_RST_BYTE;
        endcase
        if (!sfrReq.rdEn)
            rdData_next = rdData_reg;
    end

    // register stage, everything clears to zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch1Cc_reg     <= `CCA_RST_WORD;
            ch1Reload_reg <= `CCA_RST_WORD;
            ch2Mode_reg   <= cca_mode_t'(`CCA_RST_BYTE);
            rdData_reg    <= `CCA_RST_BYTE;
            rdValid_reg   <= 1'b0;
            compEnSet_reg <= 1'b0;
            compEnClr_reg <= 1'b0;
        end
        else
        begin
            ch1Cc_reg     <= ch1Cc_next;
            ch1Reload_reg <= ch1Reload_next;
            ch2Mode_reg   <= ch2Mode_next;
            rdData_reg    <= rdData_next;
            rdValid_reg   <= sfrReq.rdEn;
            compEnSet_reg <= compEnSet_next;
            compEnClr_reg <= compEnClr_next;
        end
    end

    // flag masking is a plain gate so a flag raised while enabled shows at once
    assign ch1IrqReq    = ch1Flag & ch1ModeIn.flagInterruptEnable;
    assign ch2IrqReq    = ch2Flag & ch2Mode_reg.flagInterruptEnable;
    assign ch1CompEnSet = compEnSet_reg;
    assign ch1CompEnClr = compEnClr_reg;
    assign sfrRdData    = rdData_reg;
    assign sfrRdValid   = rdValid_reg;
    assign ch2ModeOut   = ch2Mode_reg;

    // =================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    low_write_clear_a: assert property (wrCh1Low |=> ch1CompEnClr && !ch1CompEnSet)
        else $error("low byte write did not clear comparator enable");
    high_write_set_a: assert property (wrCh1High |=> ch1CompEnSet && !ch1CompEnClr)
        else $error("high byte write did not set comparator enable");
    ch2_comp_en_a: assert property (sfrReq.wrEn && sfrReq.addr == `CCA_ADDR_CH2_HIGH
        |=> ch2Mode_reg.comparatorEnable)
        else $error("channel 2 high write did not set comparator enable");
    alias_write_a: assert property (wrCh1Low && reloadAliasSelect
        |=> ch1Reload_reg[7:0] == $past(sfrReq.wrData))
        else $error("aliased write missed reload value");
    low_read_a: assert property (sfrReq.rdEn && sfrReq.addr == `CCA_ADDR_CH1_LOW && !reloadAliasSelect
        |=> sfrRdValid && sfrRdData == $past(ch1Cc_reg[7:0]))
        else $error("low byte read wrong");
    capture_copy_a: assert property (ch1Cap && !wrCh1Low && !wrCh1High |=> ch1Cc_reg == $past(ch1CapVal))
        else $error("capture not copied");
    irq_mask_a: assert property (!ch2Mode_reg.flagInterruptEnable |-> !ch2IrqReq)
        else $error("masked flag raised interrupt");
    // a byte write or a capture in the same cycle outranks these hardware updates
    reload_copy_a: assert property (ch1Reload && !ch1Cap && !wrCh1Low && !wrCh1High
        |=> ch1Cc_reg == $past(ch1Reload_reg))
        else $error("narrow pwm reload not applied");
    freq_step_a: assert property (ch1Step && !ch1Reload && !ch1Cap && !wrCh1Low && !wrCh1High
        |=> ch1Cc_reg[7:0] == 8'($past(ch1Cc_reg[7:0]) + $past(ch1Cc_reg[15:8])))
        else $error("frequency step not added to low byte");
    high_read_a: assert property (sfrReq.rdEn && sfrReq.addr == `CCA_ADDR_CH1_HIGH && !reloadAliasSelect
        |=> sfrRdValid && sfrRdData == $past(ch1Cc_reg[15:8]))
        else $error("high byte read wrong");
    mode_write_a: assert property (sfrReq.wrEn && sfrReq.addr == `CCA_ADDR_CH2_MODE
        |=> ch2Mode_reg == $past(sfrReq.wrData))
        else $error("mode byte write lost");
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
`include "cca_cfg.svh"

module tb
    import cca_pkg::*;
;
    // =================================================================
    // stimulus and observed signals
    logic         clk;
    logic         rst_n;
    cca_sfr_req_t sfrReq;
    logic [7:0]   sfrRdData;
    logic         sfrRdValid;
    logic         reloadAliasSelect;
    logic [1:0]   widthSel;
    logic [15:0]  counter;
    logic         counterTick;
    cca_mode_t    ch1ModeIn;
    logic         ch1CapPin;
    logic         ch1Flag;
    logic         ch1CompEnSet;
    logic         ch1CompEnClr;
    logic         ch1FlagSet;
    logic         ch1IrqReq;
    logic         ch1OutPin;
    logic [15:0]  ch2CompareIn;
    logic         ch2CapPin;
    logic         ch2Flag;
    logic         ch2FlagSet;
    logic         ch2IrqReq;
    logic         ch2CaptureStrobe;
    logic [15:0]  ch2CaptureValue;
    logic         ch2OutputPin;
    cca_mode_t    ch2ModeOut;
    int           fail_count;
    int           tests_run;
    int           cycles;
    logic         prevPin;

    cca_channel_regs u_cca_channel_regs (
        .clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid),
        .reloadAliasSelect(reloadAliasSelect), .widthSel(widthSel), .counter(counter),
        .counterTick(counterTick), .ch1ModeIn(ch1ModeIn), .ch1CapPin(ch1CapPin), .ch1Flag(ch1Flag),
        .ch1CompEnSet(ch1CompEnSet), .ch1CompEnClr(ch1CompEnClr), .ch1FlagSet(ch1FlagSet),
        .ch1IrqReq(ch1IrqReq), .ch1OutPin(ch1OutPin), .ch2CompareIn(ch2CompareIn), .ch2CapPin(ch2CapPin),
        .ch2Flag(ch2Flag), .ch2FlagSet(ch2FlagSet), .ch2IrqReq(ch2IrqReq),
        .ch2CaptureStrobe(ch2CaptureStrobe), .ch2CaptureValue(ch2CaptureValue),
        .ch2OutputPin(ch2OutputPin), .ch2ModeOut(ch2ModeOut)
    );

    // =================================================================
    // clock and hang guard; 5000 cycles is far above the about 160 needed
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            $display("[FAIL] %0t: run did not finish in time", $time);
            stop_test();
        end
    end

    // =================================================================
    // shared tasks; strobes rise at one falling edge and drop at the next
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrReq = '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
        @(negedge clk);
        sfrReq = '{addr: a, wrEn: 1'b0, rdEn: 1'b0, wrData: ~d}; // stale data must not be what lands
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfrReq = '{addr: a, wrEn: 1'b0, rdEn: 1'b1, wrData: 8'h00};
        @(negedge clk);
        sfrReq = '{addr: a, wrEn: 1'b0, rdEn: 1'b0, wrData: 8'h00};
        chk(16'(sfrRdValid), 16'h0001);
        chk(16'(sfrRdData), 16'(exp));
    endtask

    task automatic tick(input logic [15:0] v);
        @(negedge clk);
        counter = v;
        counterTick = 1'b1;
        @(negedge clk);
        counterTick = 1'b0;
    endtask

    // watch a fixed window after a pin edge; the last capture in it is the one checked
    task automatic capwait(input logic exp, input logic [15:0] val);
        logic       seen;
        logic       flg;
        logic [15:0] got;
        seen = 1'b0;
        flg = 1'b0;
        got = 16'h0000;
        repeat (8)
        begin
            @(negedge clk);
            if (ch2CaptureStrobe === 1'b1)
            begin
                seen = 1'b1;
                flg = ch2FlagSet;
                got = ch2CaptureValue;
            end
        end
        chk(16'(seen), 16'(exp));
        if (exp)
        begin
            chk(got, val);
            chk(16'(flg), 16'h0001);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // =================================================================
    // main sequence
    initial
    begin
        fail_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        sfrReq = '0;
        reloadAliasSelect = 1'b0;
        widthSel = 2'h0;
        counter = 16'h0000;
        counterTick = 1'b0;
        ch1ModeIn = '0;
        ch1CapPin = 1'b0;
        ch1Flag = 1'b0;
        ch2CompareIn = 16'h0000;
        ch2CapPin = 1'b0;
        ch2Flag = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(`CCA_ADDR_CH2_MODE, 8'h00);
        rd(`CCA_ADDR_CH1_LOW, 8'h00);
        rd(`CCA_ADDR_CH1_HIGH, 8'h00);
        rd(8'h55, 8'h00);
        $display("test reset values done");
        // byte registers and comparator enable side effects
        wr(`CCA_ADDR_CH1_LOW, 8'h5a);
        chk(16'(ch1CompEnClr), 16'h0001);
        chk(16'(ch1CompEnSet), 16'h0000);
        wr(`CCA_ADDR_CH1_HIGH, 8'ha5);
        chk(16'(ch1CompEnSet), 16'h0001);
        chk(16'(ch1CompEnClr), 16'h0000);
        rd(`CCA_ADDR_CH1_LOW, 8'h5a);
        rd(`CCA_ADDR_CH1_HIGH, 8'ha5);
        reloadAliasSelect = 1'b1;
        wr(`CCA_ADDR_CH1_LOW, 8'h3c);
        wr(`CCA_ADDR_CH1_HIGH, 8'hc3);
        rd(`CCA_ADDR_CH1_LOW, 8'h3c);
        rd(`CCA_ADDR_CH1_HIGH, 8'hc3);
        reloadAliasSelect = 1'b0;
        rd(`CCA_ADDR_CH1_LOW, 8'h5a);
        rd(`CCA_ADDR_CH1_HIGH, 8'ha5);
        $display("test byte registers done");
        // mode register, channel 2 enable forcing and interrupt mask
        wr(`CCA_ADDR_CH2_MODE, 8'hff);
        rd(`CCA_ADDR_CH2_MODE, 8'hff);
        wr(`CCA_ADDR_CH2_MODE, 8'h00);
        wr(`CCA_ADDR_CH2_HIGH, 8'h00);
        chk(16'(ch2ModeOut), 16'h0040);
        wr(`CCA_ADDR_CH2_LOW, 8'h00);
        chk(16'(ch2ModeOut), 16'h0000);
        ch2Flag = 1'b1;
        wr(`CCA_ADDR_CH2_MODE, 8'h01);
        chk(16'(ch2IrqReq), 16'h0001);
        wr(`CCA_ADDR_CH2_MODE, 8'h00);
        chk(16'(ch2IrqReq), 16'h0000);
        ch2Flag = 1'b0;
        ch1Flag = 1'b1;
        ch1ModeIn = 8'h01;
        @(negedge clk);
        chk(16'(ch1IrqReq), 16'h0001);
        ch1ModeIn = 8'h00;
        @(negedge clk);
        chk(16'(ch1IrqReq), 16'h0000);
        ch1Flag = 1'b0;
        $display("test mode and interrupt done");
        // compare match with flag and toggle, then with comparator off
        ch2CompareIn = 16'h1234;
        wr(`CCA_ADDR_CH2_MODE, 8'h4c);
        prevPin = ch2OutputPin;
        tick(16'h1234);
        chk(16'(ch2FlagSet), 16'h0001);
        chk(16'(ch2OutputPin), {15'h0000, ~prevPin});
        prevPin = ch2OutputPin;
        tick(16'h1235);
        chk(16'(ch2FlagSet), 16'h0000);
        chk(16'(ch2OutputPin), 16'(prevPin));
        wr(`CCA_ADDR_CH2_MODE, 8'h0c);
        tick(16'h1234);
        chk(16'(ch2FlagSet), 16'h0000);
        chk(16'(ch2OutputPin), 16'(prevPin));
        $display("test compare done");
        // narrow against wide pwm, then frequency output
        ch2CompareIn = 16'h0140;
        wr(`CCA_ADDR_CH2_MODE, 8'h42);
        tick(16'h0050);
        chk(16'(ch2OutputPin), 16'h0001);
        wr(`CCA_ADDR_CH2_MODE, 8'hc2);
        tick(16'h0050);
        chk(16'(ch2OutputPin), 16'h0000);
        tick(16'h0150);
        chk(16'(ch2OutputPin), 16'h0001);
        // 9-bit narrow pwm sees bit 8 of the compare value
        widthSel = 2'h1;
        wr(`CCA_ADDR_CH2_MODE, 8'h42);
        tick(16'h0050);
        chk(16'(ch2OutputPin), 16'h0000);
        tick(16'h0150);
        chk(16'(ch2OutputPin), 16'h0001);
        widthSel = 2'h0;
        ch2CompareIn = 16'h0040;
        wr(`CCA_ADDR_CH2_MODE, 8'h46);
        tick(16'h1240);
        prevPin = ch2OutputPin;
        tick(16'h1240);
        chk(16'(ch2OutputPin), {15'h0000, ~prevPin});
        $display("test pwm and frequency done");
        // captures on each edge selection
        counter = 16'hbeef;
        wr(`CCA_ADDR_CH2_MODE, 8'h20);
        ch2CapPin = 1'b1;
        capwait(1'b1, 16'hbeef);
        ch2CapPin = 1'b0;
        capwait(1'b0, 16'h0000);
        wr(`CCA_ADDR_CH2_MODE, 8'h10);
        counter = 16'hcafe;
        ch2CapPin = 1'b1;
        capwait(1'b0, 16'h0000);
        ch2CapPin = 1'b0;
        capwait(1'b1, 16'hcafe);
        wr(`CCA_ADDR_CH2_MODE, 8'h30);
        counter = 16'h7001;
        ch2CapPin = 1'b1;
        capwait(1'b1, 16'h7001);
        ch1ModeIn = 8'h20;
        counter = 16'h2468;
        ch1CapPin = 1'b1;
        repeat (8) @(negedge clk);
        rd(`CCA_ADDR_CH1_LOW, 8'h68);
        rd(`CCA_ADDR_CH1_HIGH, 8'h24);
        $display("test capture done");
        // channel 1 compare, narrow pwm reload and frequency step
        ch1ModeIn = 8'h4c;
        tick(16'h2468);
        chk(16'(ch1FlagSet), 16'h0001);
        chk(16'(ch1OutPin), 16'h0001);
        ch1ModeIn = 8'h42;
        tick(16'h0100);
        chk(16'(ch1OutPin), 16'h0000);
        rd(`CCA_ADDR_CH1_LOW, 8'h3c);
        rd(`CCA_ADDR_CH1_HIGH, 8'hc3);
        ch1ModeIn = 8'h46;
        tick(16'h003c);
        chk(16'(ch1OutPin), 16'h0001);
        rd(`CCA_ADDR_CH1_LOW, 8'hff);
        $display("test channel 1 compare done");
        stop_test();
    end
endmodule
